// ### dv/cdm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************
// Fixed one-cycle memory, X and Y lanes
// ************************************
module cdm_mem_model #(
  parameter logic [31:0] SALT = 32'h5a00_0000
) (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic        y_en,
  input  wire logic [31:0] addr_x,
  input  wire logic [31:0] addr_y,
  input  wire logic [31:0] wdata_x,
  input  wire logic [31:0] wdata_y,
  output logic      [31:0] rdata_x,
  output logic      [31:0] rdata_y
);
  logic [31:0] mem [logic [31:0]];
  initial rdata_x = 32'h0000_0000;
  initial rdata_y = 32'h0000_0000;
  // Data holds one cycle only; later it toggles so a late sample shows up
  always @(posedge clk) begin
    rdata_x <= req ? (mem.exists(addr_x) ? mem[addr_x] : addr_x ^ SALT) : ~rdata_x;
    rdata_y <= req ? (mem.exists(addr_y) ? mem[addr_y] : addr_y ^ SALT) : ~rdata_y;
    if (req && we) begin
      mem[addr_x] = wdata_x;
      if (y_en) mem[addr_y] = wdata_y;
    end
  end
endmodule // cdm_mem_model
`default_nettype wire

// ### dv/cond_compute_dual_move_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdm_consts.svh"
module cond_compute_dual_move_exec_test;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, ins_valid, ins_cond_present;
  logic ins_cond_true, ins_premodify, ins_dm_dir, ins_pm_dir, cmp_go, cmp_y_en;
  logic dm_req, dm_we, dm_y_en, pm_req, pm_we, pm_y_en, e;
  logic rf_dm_we_x, rf_dm_we_y, rf_pm_we_x, rf_pm_we_y;
  logic [11:0] paddr;
  logic [38:0] ins_compute, cmp_field;
  logic [3:0]  ins_dm_dreg, ins_pm_dreg, cmp_unit, rf_dm_idx, rf_pm_idx;
  logic [2:0]  ins_dm_isel, ins_dm_msel, ins_pm_isel, ins_pm_msel;
  logic [31:0] pwdata, prdata, q, ctrl, st_dm_x, st_dm_y, st_pm_x, st_pm_y;
  logic [31:0] dm_addr_x, dm_addr_y, dm_wdata_x, dm_wdata_y, dm_rdata_x, dm_rdata_y;
  logic [31:0] pm_addr_x, pm_addr_y, pm_wdata_x, pm_wdata_y, pm_rdata_x, pm_rdata_y;
  logic [31:0] rf_dm_wx, rf_dm_wy, rf_pm_wx, rf_pm_wy;
  logic [31:0] idx [16];
  logic [31:0] mdf [16];
  logic [31:0] dref [logic [31:0]];
  logic [31:0] pref [logic [31:0]];
  logic [4:0]  modes [7] = '{5'h00, 5'h01, 5'h09, 5'h11, 5'h19, 5'h06, 5'h07};
  int          n_fail, check_count, n_run, n_sup, cyc;

  cdm_exec u_dut (.*);
  cdm_mem_model #(.SALT(32'h5a00_0000)) u_dm (.clk(clk), .req(dm_req), .we(dm_we),
    .y_en(dm_y_en), .addr_x(dm_addr_x), .addr_y(dm_addr_y), .wdata_x(dm_wdata_x),
    .wdata_y(dm_wdata_y), .rdata_x(dm_rdata_x), .rdata_y(dm_rdata_y));
  cdm_mem_model #(.SALT(32'h3c00_0000)) u_pm (.clk(clk), .req(pm_req), .we(pm_we),
    .y_en(pm_y_en), .addr_x(pm_addr_x), .addr_y(pm_addr_y), .wdata_x(pm_wdata_x),
    .wdata_y(pm_wdata_y), .rdata_x(pm_rdata_x), .rdata_y(pm_rdata_y));

  // Free-running 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      finish_test;
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Expected memory word: last store, else the seeded fill pattern
  function automatic logic [31:0] mrd(input logic p, input logic [31:0] a);
    if (p) return pref.exists(a) ? pref[a] : a ^ 32'h3c00_0000;
    return dref.exists(a) ? dref[a] : a ^ 32'h5a00_0000;
  endfunction

  // One APB transfer; only the bench timeout ends a wait for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Issue one dual-move instruction and compare against the reference
  task automatic exec(input logic cp, ct, pre, input logic [38:0] cf, input logic dd, pd,
                      input logic [3:0] dr, pr, input logic [2:0] di, dmi, pi, pmi);
    logic run, sd, bcd, bcp;
    logic [31:0] k, ax, px, sx, sy, tx, ty;
    run = !cp || ct;
    sd = ctrl[0];
    k = ctrl[4:3] == 2'h1 ? 32'h0000_0002 : ctrl[4:3] == 2'h2 ? 32'h0000_0004 : 32'h0000_0001;
    bcd = ctrl[1] && di == 3'h1 && !dd;
    bcp = ctrl[2] && pi == 3'h1 && !pd;
    ax = idx[di];
    px = idx[8 + pi];
    {sx, sy, tx, ty} = {$urandom, $urandom, $urandom, $urandom};
    @(posedge clk);
    {ins_valid, ins_cond_present, ins_cond_true, ins_premodify} <= {1'b1, cp, ct, pre};
    {ins_compute, ins_dm_dir, ins_pm_dir, ins_dm_dreg, ins_pm_dreg} <= {cf, dd, pd, dr, pr};
    {ins_dm_isel, ins_dm_msel, ins_pm_isel, ins_pm_msel} <= {di, dmi, pi, pmi};
    {st_dm_x, st_dm_y, st_pm_x, st_pm_y} <= {sx, sy, tx, ty};
    @(posedge clk);
    ins_valid <= 1'b0;
    // Issue outputs stand for the one cycle after the taking edge
    #1;
    chk({dm_req, pm_req}, {run, run});
    chk(cmp_go, run && cf != 0);
    if (run) begin
      chk(cmp_unit, cf == 0 ? 1 : cf[38:37] == 2'b01 ? 4 : cf[38:37] == 2'b10 ? 8 : 2);
      chk(cmp_field, cf);
      if (cf != 0) chk(cmp_y_en, sd);
      chk({dm_we, pm_we}, {dd, pd});
      chk({dm_addr_x, pm_addr_x}, {ax, px});
      chk({dm_y_en, pm_y_en}, {sd && !bcd, sd && !bcp});
      if (sd || bcd) chk(dm_addr_y, bcd ? ax : ax + k);
      if (sd || bcp) chk(pm_addr_y, bcp ? px : px + k);
      if (dd) chk({dm_wdata_x, dm_wdata_y}, {sx, sy});
      if (pd) chk({pm_wdata_x, pm_wdata_y}, {tx, ty});
    end
    @(posedge clk);
    @(posedge clk);
    #1;
    chk({rf_dm_we_x, rf_dm_we_y}, {run && !dd, run && !dd && (sd || bcd)});
    chk({rf_pm_we_x, rf_pm_we_y}, {run && !pd, run && !pd && (sd || bcp)});
    if (run && !dd) begin
      chk({rf_dm_idx, rf_dm_wx}, {dr, mrd(0, ax)});
      if (sd || bcd) chk(rf_dm_wy, mrd(0, bcd ? ax : ax + k));
    end
    if (run && !pd) begin
      chk({rf_pm_idx, rf_pm_wx}, {pr, mrd(1, px)});
      if (sd || bcp) chk(rf_pm_wy, mrd(1, bcp ? px : px + k));
    end
    if (run) begin
      if (dd) dref[ax] = sx;
      if (dd && sd) dref[ax + k] = sy;
      if (pd) pref[px] = tx;
      if (pd && sd) pref[px + k] = ty;
      idx[di] = ax + mdf[dmi];
      idx[8 + pi] = px + mdf[8 + pmi];
      n_run++;
    end else n_sup++;
  endtask

  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, ins_valid, ins_cond_present} = '0;
    {ins_cond_true, ins_premodify, ins_compute, ins_dm_dir, ins_pm_dir} = '0;
    {ins_dm_dreg, ins_pm_dreg, ins_dm_isel, ins_dm_msel, ins_pm_isel, ins_pm_msel} = '0;
    {st_dm_x, st_dm_y, st_pm_x, st_pm_y} = '0;
    {n_fail, check_count, n_run, n_sup, cyc} = '0;
    rst = 1'b1;
    void'($urandom(32'hb624));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `CDM_OFF_CTRL, 32'h0000_0000);
    chk(q, `CDM_CTRL_RST);
    for (int n = 0; n < 16; n++) begin
      idx[n] = $urandom % 256;
      mdf[n] = $urandom % 8;
      apb(1'b1, {`CDM_PAGE_IDX, 4'(n), 2'b00}, idx[n]);
      apb(1'b1, {`CDM_PAGE_MOD, 4'(n), 2'b00}, mdf[n]);
      apb(1'b0, {`CDM_PAGE_IDX, 4'(n), 2'b00}, 32'h0000_0000);
      chk(q, idx[n]);
    end
    apb(1'b0, 12'h0c0, 32'h0000_0000);
    chk({e, q}, {1'b1, 32'h0000_0000});
    // Every lane mode, widths and broadcast, with random instructions
    foreach (modes[m]) begin
      ctrl = {27'h0, modes[m]};
      apb(1'b1, `CDM_OFF_CTRL, ctrl);
      repeat (8) exec(1'($urandom % 3 == 0), 1'($urandom), 1'b0,
                      ($urandom % 4 == 0) ? '0 : {2'($urandom % 3 + 1), 37'($urandom)},
                      1'($urandom), 1'($urandom), 4'($urandom), 4'($urandom),
                      ($urandom % 2) ? 3'h1 : 3'($urandom), 3'($urandom),
                      ($urandom % 2) ? 3'h1 : 3'($urandom), 3'($urandom));
    end
    exec(1'b0, 1'b0, 1'b1, '0, 1'b0, 1'b0, 4'h2, 4'h3, 3'h4, 3'h5, 3'h6, 3'h7);
    apb(1'b0, `CDM_OFF_FLAG, 32'h0000_0000);
    chk(q[`CDM_FLAG_PREM], 1'b1);
    apb(1'b0, `CDM_OFF_STAT, 32'h0000_0000);
    chk(q, {16'(n_sup), 16'(n_run)});
    finish_test;
  end
endmodule // cond_compute_dual_move_exec_test
`default_nettype wire

// ### pkg/cdm_consts.svh
`ifndef CDM_CONSTS_SVH
`define CDM_CONSTS_SVH
// ***********************************************
// Register map, byte offsets on the APB side
// ***********************************************
`define CDM_OFF_CTRL   12'h000
`define CDM_OFF_STAT   12'h004
`define CDM_OFF_FLAG   12'h008
`define CDM_PAGE_IDX   6'h01
`define CDM_PAGE_MOD   6'h02
// Control fields
`define CDM_CTRL_SIMD  0
`define CDM_CTRL_BC1   1
`define CDM_CTRL_BC9   2
`define CDM_CTRL_WLO   3
`define CDM_CTRL_RST   32'h0000_0000
// Flag fields
`define CDM_FLAG_PREM  0
// ***********************************************
// Access behaviour
// ***********************************************
`define CDM_DIR_LOAD   1'b0
`define CDM_DIR_STORE  1'b1
`define CDM_K_NW       32'h0000_0001
`define CDM_K_SW       32'h0000_0002
`define CDM_K_BW       32'h0000_0004
`define CDM_K_BC       32'h0000_0000
`define CDM_BC_SEL     3'h1
`define CDM_COMP_W     39
`endif

// ### pkg/cdm_dag_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cdm_dag_if #(parameter int AW = 32);
  logic          go;
  logic [2:0]    isel;
  logic [2:0]    msel;
  logic [AW-1:0] addr;
  logic          ld_en;
  logic          ld_mod;
  logic [2:0]    ld_sel;
  logic [AW-1:0] ld_data;
  logic [AW-1:0] rd_idx;
  logic [AW-1:0] rd_mod;
  modport master (output go, isel, msel, ld_en, ld_mod, ld_sel, ld_data,
                  input addr, rd_idx, rd_mod);
  modport gen (input go, isel, msel, ld_en, ld_mod, ld_sel, ld_data,
               output addr, rd_idx, rd_mod);
endinterface
`default_nettype wire

// ### pkg/cdm_pkg.sv
package cdm_pkg;
  // Access width selected in the control register
  typedef enum logic [1:0] {
    CDM_W_NW = 2'h0,
    CDM_W_SW = 2'h1,
    CDM_W_BW = 2'h2
  } cdm_width_e;
  // Unit that runs the compute field, one-hot
  typedef enum logic [3:0] {
    CDM_U_NONE  = 4'h1,
    CDM_U_ALU   = 4'h2,
    CDM_U_MUL   = 4'h4,
    CDM_U_SHIFT = 4'h8
  } cdm_unit_e;
endpackage

// ### rtl/cdm_dag.sv
`timescale 1ns/1ps
`default_nettype none
module cdm_dag #(
  parameter int AW = 32
) (
  input  wire logic clk,
  input  wire logic rst,
  cdm_dag_if.gen    bus
);
  logic [AW-1:0] idx_r [8];
  logic [AW-1:0] mod_r [8];

  // Address is the index as it stands, before any modify
  assign bus.addr   = idx_r[bus.isel];
  assign bus.rd_idx = idx_r[bus.ld_sel];
  assign bus.rd_mod = mod_r[bus.ld_sel];

  // Software load wins over a post-modify in the same cycle, whichever register it targets
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        idx_r[i] <= '0;
        mod_r[i] <= '0;
      end
    end else if (bus.ld_en) begin
      if (bus.ld_mod) mod_r[bus.ld_sel] <= bus.ld_data;
      else            idx_r[bus.ld_sel] <= bus.ld_data;
    end else if (bus.go) begin
      idx_r[bus.isel] <= idx_r[bus.isel] + mod_r[bus.msel];
    end
  end

  post_modify_a: assert property (@(posedge clk) disable iff (rst)
    bus.go && !bus.ld_en |=>
      idx_r[$past(bus.isel)] == $past(bus.addr) + $past(mod_r[bus.msel]))
    else $error("Index not post-modified by its modify register");
endmodule // cdm_dag
`default_nettype wire

// ### rtl/cdm_exec.sv
// How it works
// - True condition runs compute and move; false suppresses both
// - No condition present means always true
// - Compute field picks one of ALU, multiplier or shifter
// - All-zero compute field: only the two memory accesses run
// - Single lane: one data and one program access in parallel
// - Index used unmodified as address, then index plus modify written back
// - No pre-modify addressing for this form, post-modify only
// - Dual lane: compute and both accesses run in X and Y together
// - Y lane uses the complementary data register as source and target
// - Y lane address is index plus 1, 2 or 4 by width, no modify
// - Broadcast bit on index 1 or 9: reads share one address, offset 0
// - Broadcast read loads same value into X register and its partner
// - Data access uses first generator, program access the second
// - Data direction 0 loads register, 1 stores to data memory
// - Dual lane compute result goes to X target and its partner
// - Index and modify 0-7 in first generator, 8-15 in second
// - Program direction 0 loads register, 1 stores to program memory
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cdm_consts.svh"
module cdm_exec #(
  parameter int AW     = 32,
  parameter int DW     = 32,
  parameter int COMP_W = `CDM_COMP_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ins_valid,
  input  wire logic              ins_cond_present,
  input  wire logic              ins_cond_true,
  input  wire logic              ins_premodify,
  input  wire logic [COMP_W-1:0] ins_compute,
  input  wire logic              ins_dm_dir,
  input  wire logic              ins_pm_dir,
  input  wire logic [3:0]        ins_dm_dreg,
  input  wire logic [3:0]        ins_pm_dreg,
  input  wire logic [2:0]        ins_dm_isel,
  input  wire logic [2:0]        ins_dm_msel,
  input  wire logic [2:0]        ins_pm_isel,
  input  wire logic [2:0]        ins_pm_msel,
  input  wire logic [DW-1:0]     st_dm_x,
  input  wire logic [DW-1:0]     st_dm_y,
  input  wire logic [DW-1:0]     st_pm_x,
  input  wire logic [DW-1:0]     st_pm_y,
  output logic                   cmp_go,
  output logic      [3:0]        cmp_unit,
  output logic      [COMP_W-1:0] cmp_field,
  output logic                   cmp_y_en,
  output logic                   dm_req,
  output logic                   dm_we,
  output logic                   dm_y_en,
  output logic      [AW-1:0]     dm_addr_x,
  output logic      [AW-1:0]     dm_addr_y,
  output logic      [DW-1:0]     dm_wdata_x,
  output logic      [DW-1:0]     dm_wdata_y,
  input  wire logic [DW-1:0]     dm_rdata_x,
  input  wire logic [DW-1:0]     dm_rdata_y,
  output logic                   pm_req,
  output logic                   pm_we,
  output logic                   pm_y_en,
  output logic      [AW-1:0]     pm_addr_x,
  output logic      [AW-1:0]     pm_addr_y,
  output logic      [DW-1:0]     pm_wdata_x,
  output logic      [DW-1:0]     pm_wdata_y,
  input  wire logic [DW-1:0]     pm_rdata_x,
  input  wire logic [DW-1:0]     pm_rdata_y,
  output logic                   rf_dm_we_x,
  output logic                   rf_dm_we_y,
  output logic      [3:0]        rf_dm_idx,
  output logic      [DW-1:0]     rf_dm_wx,
  output logic      [DW-1:0]     rf_dm_wy,
  output logic                   rf_pm_we_x,
  output logic                   rf_pm_we_y,
  output logic      [3:0]        rf_pm_idx,
  output logic      [DW-1:0]     rf_pm_wx,
  output logic      [DW-1:0]     rf_pm_wy
);
  initial begin
    if (AW < 8 || DW < 1 || COMP_W < 2 || AW > 32 || DW > 32)
      $error("cdm_exec: unsupported width parameters");
  end

  // ***********************************************
  // Decode helpers
  // ***********************************************
  // Implicit Y offset: zero for a broadcast read, else by access width
  function automatic logic [AW-1:0] y_step(input logic bc, input logic [1:0] w);
    logic [31:0] k;
    k = `CDM_K_NW;
    if (bc)                            k = `CDM_K_BC;
    else if (w == cdm_pkg::CDM_W_SW)   k = `CDM_K_SW;
    else if (w == cdm_pkg::CDM_W_BW)   k = `CDM_K_BW;
    return k[AW-1:0];
  endfunction

  // Top two field bits pick the unit; the empty field picks none
  function automatic logic [3:0] unit_of(input logic [COMP_W-1:0] f);
    logic [3:0] u;
    u = cdm_pkg::CDM_U_ALU;
    if (f == '0)                              u = cdm_pkg::CDM_U_NONE;
    else if (f[COMP_W-1 -: 2] == 2'h1)        u = cdm_pkg::CDM_U_MUL;
    else if (f[COMP_W-1 -: 2] == 2'h2)        u = cdm_pkg::CDM_U_SHIFT;
    return u;
  endfunction

  // ***********************************************
  // Control and status registers
  // ***********************************************
  logic [31:0] ctrl_r;
  logic [15:0] exec_cnt_r;
  logic [15:0] skip_cnt_r;
  logic        prem_r;

  wire       simd    = ctrl_r[`CDM_CTRL_SIMD];
  wire       bc1     = ctrl_r[`CDM_CTRL_BC1];
  wire       bc9     = ctrl_r[`CDM_CTRL_BC9];
  wire [1:0] width   = ctrl_r[`CDM_CTRL_WLO +: 2];

  // ***********************************************
  // Issue decode
  // ***********************************************
  wire exec     = ins_valid && (!ins_cond_present || ins_cond_true);
  wire cmp_any  = ins_compute != '0;
  wire prem_set = exec && ins_premodify;

  // Per-port views: port 0 is the data bus, port 1 the program bus
  wire       p_dir  [2];
  wire [2:0] p_isel [2];
  wire [2:0] p_msel [2];
  wire [3:0] p_dreg [2];
  wire [DW-1:0] p_stx [2];
  wire [DW-1:0] p_sty [2];
  assign p_dir[0]  = ins_dm_dir;
  assign p_dir[1]  = ins_pm_dir;
  assign p_isel[0] = ins_dm_isel;
  assign p_isel[1] = ins_pm_isel;
  assign p_msel[0] = ins_dm_msel;
  assign p_msel[1] = ins_pm_msel;
  assign p_dreg[0] = ins_dm_dreg;
  assign p_dreg[1] = ins_pm_dreg;
  assign p_stx[0]  = st_dm_x;
  assign p_stx[1]  = st_pm_x;
  assign p_sty[0]  = st_dm_y;
  assign p_sty[1]  = st_pm_y;

  // Stage registers per port
  logic          req_r   [2];
  logic          we_r    [2];
  logic          yen_r   [2];
  logic [AW-1:0] ax_r    [2];
  logic [AW-1:0] ay_r    [2];
  logic [DW-1:0] wx_r    [2];
  logic [DW-1:0] wy_r    [2];
  logic          ld1_r   [2];
  logic          ld2_r   [2];
  logic          ly1_r   [2];
  logic          ly2_r   [2];
  logic          bc1_r   [2];
  logic          bc2_r   [2];
  logic          bc3_r   [2];
  logic [3:0]    ri1_r   [2];
  logic [3:0]    ri2_r   [2];
  logic          rwx_r   [2];
  logic          rwy_r   [2];
  logic [3:0]    rid_r   [2];
  logic [DW-1:0] rdx_r   [2];
  logic [DW-1:0] rdy_r   [2];
  wire  [DW-1:0] rdx_in  [2];
  wire  [DW-1:0] rdy_in  [2];
  wire  [AW-1:0] ykay    [2];
  assign rdx_in[0] = dm_rdata_x;
  assign rdx_in[1] = pm_rdata_x;
  assign rdy_in[0] = dm_rdata_y;
  assign rdy_in[1] = pm_rdata_y;

  cdm_dag_if #(.AW(AW)) dag [2] ();

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_port
      // Index 1 of the first generator or 9 of the second, read only
      wire bc_en = (g == 0) ? bc1 : bc9;
      wire bc    = bc_en && p_isel[g] == `CDM_BC_SEL
                   && p_dir[g] == `CDM_DIR_LOAD;
      wire yact  = simd || bc;
      wire [AW-1:0] ax = dag[g].addr;
      assign ykay[g] = y_step(bc, width);

      // APB loads of this generator's index and modify registers
      wire hit_i = paddr[11:6] == `CDM_PAGE_IDX && paddr[5] == 1'(g);
      wire hit_m = paddr[11:6] == `CDM_PAGE_MOD && paddr[5] == 1'(g);
      assign dag[g].go      = exec;
      assign dag[g].isel    = p_isel[g];
      assign dag[g].msel    = p_msel[g];
      assign dag[g].ld_en   = psel && penable && pwrite && (hit_i || hit_m);
      assign dag[g].ld_mod  = hit_m;
      assign dag[g].ld_sel  = paddr[4:2];
      assign dag[g].ld_data = pwdata[AW-1:0];

      cdm_dag #(.AW(AW)) u_dag (
        .clk (clk),
        .rst (rst),
        .bus (dag[g])
      );

      // Issue stage, then two cycles to the register file write
      always_ff @(posedge clk) begin
        if (rst) begin
          req_r[g] <= 1'b0;
          we_r[g]  <= 1'b0;
          yen_r[g] <= 1'b0;
          ax_r[g]  <= '0;
          ay_r[g]  <= '0;
          wx_r[g]  <= '0;
          wy_r[g]  <= '0;
          ld1_r[g] <= 1'b0;
          ld2_r[g] <= 1'b0;
          ly1_r[g] <= 1'b0;
          ly2_r[g] <= 1'b0;
          bc1_r[g] <= 1'b0;
          bc2_r[g] <= 1'b0;
          bc3_r[g] <= 1'b0;
          ri1_r[g] <= '0;
          ri2_r[g] <= '0;
          rwx_r[g] <= 1'b0;
          rwy_r[g] <= 1'b0;
          rid_r[g] <= '0;
          rdx_r[g] <= '0;
          rdy_r[g] <= '0;
        end else begin
          req_r[g] <= exec;
          we_r[g]  <= p_dir[g];
          yen_r[g] <= exec && simd && !bc;
          ax_r[g]  <= ax;
          ay_r[g]  <= ax + ykay[g];
          wx_r[g]  <= p_stx[g];
          wy_r[g]  <= p_sty[g];
          ld1_r[g] <= exec && p_dir[g] == `CDM_DIR_LOAD;
          ly1_r[g] <= exec && yact && p_dir[g] == `CDM_DIR_LOAD;
          bc1_r[g] <= bc;
          ri1_r[g] <= p_dreg[g];
          ld2_r[g] <= ld1_r[g];
          ly2_r[g] <= ly1_r[g];
          bc2_r[g] <= bc1_r[g];
          ri2_r[g] <= ri1_r[g];
          // Loads land two cycles after compute issue
          rwx_r[g] <= ld2_r[g];
          rwy_r[g] <= ly2_r[g];
          rid_r[g] <= ri2_r[g];
          rdx_r[g] <= rdx_in[g];
          rdy_r[g] <= bc2_r[g] ? rdx_in[g] : rdy_in[g];
          bc3_r[g] <= bc2_r[g];
        end
      end
    end
  endgenerate

  // ***********************************************
  // Port wiring
  // ***********************************************
  assign dm_req     = req_r[0];
  assign dm_we      = we_r[0];
  assign dm_y_en    = yen_r[0];
  assign dm_addr_x  = ax_r[0];
  assign dm_addr_y  = ay_r[0];
  assign dm_wdata_x = wx_r[0];
  assign dm_wdata_y = wy_r[0];
  assign pm_req     = req_r[1];
  assign pm_we      = we_r[1];
  assign pm_y_en    = yen_r[1];
  assign pm_addr_x  = ax_r[1];
  assign pm_addr_y  = ay_r[1];
  assign pm_wdata_x = wx_r[1];
  assign pm_wdata_y = wy_r[1];
  assign rf_dm_we_x = rwx_r[0];
  assign rf_dm_we_y = rwy_r[0];
  assign rf_dm_idx  = rid_r[0];
  assign rf_dm_wx   = rdx_r[0];
  assign rf_dm_wy   = rdy_r[0];
  assign rf_pm_we_x = rwx_r[1];
  assign rf_pm_we_y = rwy_r[1];
  assign rf_pm_idx  = rid_r[1];
  assign rf_pm_wx   = rdx_r[1];
  assign rf_pm_wy   = rdy_r[1];

  // ***********************************************
  // Compute issue
  // ***********************************************
  // Operands are read by the unit in the issue cycle, before loads land
  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_go    <= 1'b0;
      cmp_unit  <= cdm_pkg::CDM_U_NONE;
      cmp_field <= '0;
      cmp_y_en  <= 1'b0;
    end else begin
      cmp_go    <= exec && cmp_any;
      cmp_unit  <= exec ? unit_of(ins_compute) : cdm_pkg::CDM_U_NONE;
      cmp_field <= ins_compute;
      cmp_y_en  <= exec && cmp_any && simd;
    end
  end

  // ***********************************************
  // APB slave, zero wait states
  // ***********************************************
  wire wr_acc  = psel && penable && pwrite;
  wire hit_c   = paddr == `CDM_OFF_CTRL;
  wire hit_s   = paddr == `CDM_OFF_STAT;
  wire hit_f   = paddr == `CDM_OFF_FLAG;
  wire hit_im  = paddr[11:6] == `CDM_PAGE_IDX || paddr[11:6] == `CDM_PAGE_MOD;
  wire mapped  = hit_c || hit_s || hit_f || (hit_im && paddr[1:0] == 2'h0);
  // Interface arrays take constant indices only, so pick the generator by hand
  wire [AW-1:0] rd_idx_sel = paddr[5] ? dag[1].rd_idx : dag[0].rd_idx;
  wire [AW-1:0] rd_mod_sel = paddr[5] ? dag[1].rd_mod : dag[0].rd_mod;
  wire [AW-1:0] im_val     = paddr[6] ? rd_idx_sel : rd_mod_sel;
  wire [31:0] im_word  = 32'(im_val);
  // Flag clears by writing one; a new event in the same cycle wins
  wire prem_clr = wr_acc && hit_f && pwdata[`CDM_FLAG_PREM];

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = hit_c ? ctrl_r :
                   hit_s ? {skip_cnt_r, exec_cnt_r} :
                   hit_f ? {31'h0000_0000, prem_r} :
                   hit_im ? im_word : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r     <= `CDM_CTRL_RST;
      exec_cnt_r <= '0;
      skip_cnt_r <= '0;
      prem_r     <= 1'b0;
    end else begin
      if (wr_acc && hit_c) ctrl_r <= {27'h000_0000, pwdata[4:0]};
      if (exec) exec_cnt_r <= exec_cnt_r + 16'h0001;
      if (ins_valid && !exec) skip_cnt_r <= skip_cnt_r + 16'h0001;
      prem_r <= prem_set || (prem_r && !prem_clr);
    end
  end

  // ***********************************************
  // Checks
  // ***********************************************
  suppress_false_a: assert property (@(posedge clk) disable iff (rst)
    ins_valid && ins_cond_present && !ins_cond_true |=> !dm_req && !pm_req && !cmp_go)
    else $error("False condition did not suppress the instruction");
  no_cond_runs_a: assert property (@(posedge clk) disable iff (rst)
    ins_valid && !ins_cond_present |=> dm_req && pm_req)
    else $error("Unconditional instruction did not run");
  unit_pick_a: assert property (@(posedge clk) disable iff (rst)
    cmp_go |-> cmp_unit != cdm_pkg::CDM_U_NONE && $onehot(cmp_unit))
    else $error("Compute issued without exactly one unit");
  empty_compute_a: assert property (@(posedge clk) disable iff (rst)
    exec && ins_compute == '0 |=> !cmp_go && dm_req && pm_req)
    else $error("Empty compute field was not a pure dual move");
  addr_unmod_a: assert property (@(posedge clk) disable iff (rst)
    exec && !dag[0].ld_en |=> dm_addr_x == $past(dag[0].addr))
    else $error("Data address was not the unmodified index");
  y_offset_a: assert property (@(posedge clk) disable iff (rst)
    exec && simd && !g_port[1].bc && width == cdm_pkg::CDM_W_SW
      |=> pm_addr_y == pm_addr_x + 2)
    else $error("Y lane short-word offset wrong");
  bcast_same_a: assert property (@(posedge clk) disable iff (rst)
    rf_dm_we_y && bc3_r[0] |-> rf_dm_wy == rf_dm_wx && rf_dm_we_x)
    else $error("Broadcast read loaded different values");
  dir_map_a: assert property (@(posedge clk) disable iff (rst)
    exec |=> dm_we == $past(ins_dm_dir) && pm_we == $past(ins_pm_dir))
    else $error("Transfer direction does not follow direction bit");
  load_after_a: assert property (@(posedge clk) disable iff (rst)
    dm_req && !dm_we |-> ##2 rf_dm_we_x)
    else $error("Data load did not land two cycles after issue");
endmodule // cdm_exec
`default_nettype wire
